// *** tb/mflr_master_model.sv ***
// Far side model: fieldbus master that takes diagnosis telegrams and sends acknowledges
`timescale 1ns/10ps
module mflr_master_model (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	input  wire logic                        diag_valid,
	input  wire logic [mflr_pkg::CODE_W-1:0] diag_code,
	input  wire logic [3:0]                  ready_delay,
	input  wire logic                        ack_req,
	output logic                             diag_ready,
	output logic                             fieldbus_ack,
	output logic [mflr_pkg::CODE_W-1:0]      last_code,
	output logic [7:0]                       taken_cnt
);
	logic [3:0] wait_q;

	// Acknowledge is a plain level; the block itself finds the rising edge
	assign fieldbus_ack = ack_req;

	// Ready is only offered against a pending telegram, after a chosen stall
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			diag_ready <= 1'h0;
			last_code  <= 4'h0;
			taken_cnt  <= 8'h00;
			wait_q     <= 4'h0;
		end else if (diag_valid && diag_ready) begin
			last_code  <= diag_code;
			taken_cnt  <= taken_cnt + 8'h01;
			diag_ready <= 1'h0;
			wait_q     <= 4'h0;
		end else if (diag_valid && wait_q >= ready_delay) begin
			diag_ready <= 1'h1;
		end else if (diag_valid) begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the motor fault latch and report block
`timescale 1ns/10ps
module tb;
	logic        core_clk, reset_n, auto_ack_en, panel_ack, fb_req, diag_supported, diag_ready, fieldbus_ack;
	logic [15:0] cond;
	logic [1:0]  fault_output_cfg;
	logic [2:0]  mf_in, mf_en;
	logic [3:0]  hist_index, ready_delay, hist_code, diag_code, last_code;
	logic [15:0] fault_latched;
	logic        fault_present, fieldbus_fault_flag, red_led, relay_out, lamp_out, diag_valid, hist_valid;
	logic [31:0] diag_stamp, hist_stamp, seconds;
	logic [4:0]  hist_count;
	logic [7:0]  taken_cnt, prev_cnt;
	logic [31:0] s0;
	int          miscompares, comparisons, cycles;

	mflr_top #(.TICKS_PER_SEC(10)) mflr_top_inst (
		.core_clk(core_clk), .reset_n(reset_n),
		.thermal_trip(cond[0]), .phase_loss(cond[1]), .phase_imbalance(cond[2]), .locked_rotor(cond[3]),
		.thermal_warn(cond[4]), .thermistor_input(cond[5]), .thermistor_wiring_fault({cond[6], 1'h0}),
		.checkback_fault({1'h0, cond[7], 1'h0}), .low_current_trip(cond[8]), .low_current_warn(cond[9]),
		.high_current_trip(cond[10]), .high_current_warn(cond[11]), .earth_fault_trip(cond[12]),
		.earth_fault_warn(cond[13]), .selftest_fail(cond[14]), .actuator_timeout(cond[15]),
		.auto_ack_en(auto_ack_en), .fault_output_cfg(fault_output_cfg), .panel_ack(panel_ack),
		.fieldbus_ack(fieldbus_ack), .multifunction_inputs(mf_in), .multifunction_ack_en(mf_en),
		.diag_supported(diag_supported), .diag_ready(diag_ready), .hist_index(hist_index),
		.fault_latched(fault_latched), .fault_present(fault_present), .fieldbus_fault_flag(fieldbus_fault_flag),
		.red_led(red_led), .summary_fault_relay_output(relay_out), .summary_fault_lamp_output(lamp_out),
		.diag_valid(diag_valid), .diag_code(diag_code), .diag_stamp(diag_stamp), .hist_code(hist_code),
		.hist_stamp(hist_stamp), .hist_valid(hist_valid), .hist_count(hist_count),
		.seconds_since_power_on(seconds));

	mflr_master_model mflr_master_model_inst (
		.core_clk(core_clk), .reset_n(reset_n), .diag_valid(diag_valid), .diag_code(diag_code),
		.ready_delay(ready_delay), .ack_req(fb_req), .diag_ready(diag_ready), .fieldbus_ack(fieldbus_ack),
		.last_code(last_code), .taken_cnt(taken_cnt));

	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic summarize();
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Level held two cycles, then released so the next acknowledge has a fresh edge
	task automatic ack(input int src);
		@(negedge core_clk);
		case (src)
			0: panel_ack = 1'h1;
			1: fb_req = 1'h1;
			default: mf_in = 3'h2;
		endcase
		wait_n(2);
		panel_ack = 1'h0;
		fb_req = 1'h0;
		mf_in = 3'h0;
		wait_n(4);
	endtask

	task automatic pulse_fault(input int c);
		cond[c] = 1'h1;
		wait_n(4);
		cond[c] = 1'h0;
		wait_n(4);
	endtask

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		reset_n = 1'h0;
		cond = 16'h0000;
		auto_ack_en = 1'h0;
		panel_ack = 1'h0;
		fb_req = 1'h0;
		mf_in = 3'h0;
		mf_en = 3'h2;
		diag_supported = 1'h1;
		fault_output_cfg = 2'h3;
		hist_index = 4'h0;
		ready_delay = 4'h0;
		wait_n(5);
		reset_n = 1'h1;
		wait_n(1);
		chk_val("hist_count", 32'h0000_0000, {27'h0, hist_count});
		chk_bit("hist_valid", 1'h0, hist_valid);
		chk_val("fault_latched", 32'h0000_0000, {16'h0, fault_latched});
		for (int i = 0; i < 16; i++) begin
			ready_delay = 4'(i % 4);
			prev_cnt = taken_cnt;
			cond[i] = 1'h1;
			wait_n(4);
			chk_val("fault_latched", 32'h0000_0001 << i, {16'h0, fault_latched});
			chk_bit("fieldbus_fault_flag", 1'h1, fieldbus_fault_flag);
			chk_bit("red_led", 1'h1, red_led);
			chk_bit("fault_present", 1'h1, fault_present);
			cond[i] = 1'h0;
			wait_n(4);
			chk_val("fault_held", 32'h0000_0001 << i, {16'h0, fault_latched});
			for (int k = 0; k < 30 && taken_cnt == prev_cnt; k++)
				wait_n(1);
			chk_val("diag_taken", {24'h0, prev_cnt + 8'h01}, {24'h0, taken_cnt});
			chk_val("diag_code", i, {28'h0, last_code});
			chk_bit("diag_idle", 1'h0, diag_valid);
			ack(i % 3);
			chk_val("fault_cleared", 32'h0000_0000, {16'h0, fault_latched});
			chk_bit("red_led_off", 1'h0, red_led);
			chk_bit("flag_off", 1'h0, fieldbus_fault_flag);
			chk_bit("present_off", 1'h0, fault_present);
		end
		chk_val("hist_count", 32'h0000_0010, {27'h0, hist_count});
		chk_val("hist_newest", 32'h0000_000f, {28'h0, hist_code});
		chk_bit("stamp_bound", 1'h1, hist_stamp <= seconds);
		chk_bit("hist_valid_full", 1'h1, hist_valid);
		chk_bit("diag_stamp_bound", 1'h1, diag_stamp != 32'h0 && diag_stamp <= seconds);
		hist_index = 4'hf;
		wait_n(1);
		chk_val("hist_oldest", 32'h0000_0000, {28'h0, hist_code});
		pulse_fault(1);
		ack(0);
		chk_val("hist_oldest_new", 32'h0000_0001, {28'h0, hist_code});
		chk_val("hist_count_sat", 32'h0000_0010, {27'h0, hist_count});
		hist_index = 4'h0;
		wait_n(1);
		chk_val("hist_newest_new", 32'h0000_0001, {28'h0, hist_code});
		cond[12] = 1'h1;
		wait_n(4);
		ack(0);
		chk_val("ack_refused", 32'h0000_1000, {16'h0, fault_latched});
		cond[12] = 1'h0;
		ack(1);
		chk_val("ack_after_gone", 32'h0000_0000, {16'h0, fault_latched});
		pulse_fault(2);
		for (int c = 0; c < 4; c++) begin
			fault_output_cfg = 2'(c);
			wait_n(3);
			chk_bit("relay_output", c[0], relay_out);
			chk_bit("lamp_output", c[1], lamp_out);
		end
		ack(2);
		chk_bit("relay_idle", 1'h0, relay_out);
		chk_bit("lamp_idle", 1'h0, lamp_out);
		diag_supported = 1'h0;
		prev_cnt = taken_cnt;
		auto_ack_en = 1'h1;
		pulse_fault(0);
		chk_val("auto_trip", 32'h0000_0000, {16'h0, fault_latched});
		cond[8] = 1'h1;
		wait_n(8);
		chk_val("auto_held", 32'h0000_0100, {16'h0, fault_latched});
		cond[8] = 1'h0;
		wait_n(4);
		pulse_fault(4);
		chk_val("auto_warn_kept", 32'h0000_0010, {16'h0, fault_latched});
		auto_ack_en = 1'h0;
		ack(0);
		chk_val("warn_cleared", 32'h0000_0000, {16'h0, fault_latched});
		chk_val("diag_quiet", {24'h0, prev_cnt}, {24'h0, taken_cnt});
		chk_bit("diag_quiet_valid", 1'h0, diag_valid);
		s0 = seconds;
		wait_n(10);
		chk_val("seconds_rate", s0 + 32'h0000_0001, seconds);
		reset_n = 1'h0;
		wait_n(2);
		reset_n = 1'h1;
		wait_n(1);
		chk_val("hist_after_reset", 32'h0000_0000, {27'h0, hist_count});
		chk_val("seconds_after_reset", 32'h0000_0000, seconds);
		summarize();
	end
endmodule

// *** verilog/mflr_diag.sv ***
// Diagnosis telegram launcher: one request per new fault, held until taken or replaced by a newer fault
`timescale 1ns/10ps
module mflr_diag (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	mflr_event_if.sink                       evt,
	input  wire logic                        diag_supported,
	input  wire logic                        diag_ready,
	output logic                             diag_valid,
	output logic [mflr_pkg::CODE_W-1:0]      diag_code,
	output logic [mflr_pkg::TIME_W-1:0]      diag_stamp
);
	typedef struct packed {
		logic                        valid;
		logic [mflr_pkg::CODE_W-1:0] code;
		logic [mflr_pkg::TIME_W-1:0] stamp;
	} mflr_diag_t;
	mflr_diag_t s_q;
	mflr_diag_t s_d;
	always_comb begin
		s_d = s_q;
		if (s_q.valid && diag_ready)
			s_d.valid = 1'b0;
		// A newer fault replaces an unsent one; the newest detail matters most
		if (evt.valid && diag_supported) begin
			s_d.valid = 1'b1;
			s_d.code = evt.code;
			s_d.stamp = evt.stamp;
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign diag_valid = s_q.valid;
	assign diag_code = s_q.code;
	assign diag_stamp = s_q.stamp;
	diag_issue_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		evt.valid && diag_supported |=> diag_valid && diag_code == $past(evt.code))
		else $error("diagnosis not issued");
	diag_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		diag_valid && !diag_ready && !evt.valid |=> diag_valid)
		else $error("diagnosis dropped before taken");
endmodule

// *** verilog/mflr_event_if.sv ***
// New fault event carried from the latch core to history and diagnosis logic
`timescale 1ns/10ps
interface mflr_event_if;
	logic                        valid;
	logic [mflr_pkg::CODE_W-1:0] code;
	logic [mflr_pkg::TIME_W-1:0] stamp;
	modport source (output valid, output code, output stamp);
	modport sink   (input valid, input code, input stamp);
endinterface

// *** verilog/mflr_history.sv ***
// Volatile ring of the most recent fault codes with time stamps
`timescale 1ns/10ps
module mflr_history #(
	parameter int DEPTH = mflr_pkg::HIST_DEPTH
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	mflr_event_if.sink                       evt,
	input  wire logic [3:0]                  rd_index,
	output logic [mflr_pkg::CODE_W-1:0]      rd_code,
	output logic [mflr_pkg::TIME_W-1:0]      rd_stamp,
	output logic                             rd_valid,
	output logic [4:0]                       count
);
	typedef struct packed {
		mflr_pkg::mflr_entry_t [DEPTH-1:0] mem;
		logic [DEPTH-1:0]                  used;
		logic [3:0]                        wr_ptr;
		logic [4:0]                        cnt;
	} mflr_hist_t;
	mflr_hist_t s_q;
	mflr_hist_t s_d;
	logic [3:0] slot;
	always_comb begin
		s_d = s_q;
		if (evt.valid) begin
			// Wraps onto the oldest entry once full
			s_d.mem[s_q.wr_ptr] = '{code: evt.code, stamp: evt.stamp};
			s_d.used[s_q.wr_ptr] = 1'b1;
			s_d.wr_ptr = s_q.wr_ptr + 4'h1;
			if (s_q.cnt != 5'(DEPTH))
				s_d.cnt = s_q.cnt + 5'h1;
		end
	end
	// Reset empties the history; nothing survives power loss
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	// Index 0 is the newest entry
	assign slot = s_q.wr_ptr - 4'h1 - rd_index;
	assign rd_code = s_q.mem[slot].code;
	assign rd_stamp = s_q.mem[slot].stamp;
	assign rd_valid = s_q.used[slot] && (5'(rd_index) < s_q.cnt);
	assign count = s_q.cnt;
	hist_cap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_q.cnt <= 5'(DEPTH)) else $error("history count above depth");
	hist_grow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		evt.valid && s_q.cnt < 5'(DEPTH) |=> s_q.cnt == $past(s_q.cnt) + 5'h1)
		else $error("history did not grow");
	hist_wrap_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		evt.valid && s_q.cnt == 5'(DEPTH));
endmodule

// *** verilog/mflr_pkg.sv ***
// Shared constants and types for the motor fault latch and report block
package mflr_pkg;
	localparam int NUM_CODES = 16;
	localparam int CODE_W = 4;
	localparam int HIST_DEPTH = 16;
	localparam int TIME_W = 32;
	localparam int CLK_HZ = 25_000_000;
	localparam int TICKS_PER_SEC = CLK_HZ;
	localparam logic [CODE_W-1:0] CODE_THERMAL_TRIP = 4'h0;
	localparam logic [CODE_W-1:0] CODE_PHASE_LOSS = 4'h1;
	localparam logic [CODE_W-1:0] CODE_IMBALANCE = 4'h2;
	localparam logic [CODE_W-1:0] CODE_LOCKED_ROTOR = 4'h3;
	localparam logic [CODE_W-1:0] CODE_THERMAL_WARN = 4'h4;
	localparam logic [CODE_W-1:0] CODE_THERMISTOR_HOT = 4'h5;
	localparam logic [CODE_W-1:0] CODE_THERMISTOR_WIRE = 4'h6;
	localparam logic [CODE_W-1:0] CODE_CHECKBACK = 4'h7;
	localparam logic [CODE_W-1:0] CODE_LOW_CUR_TRIP = 4'h8;
	localparam logic [CODE_W-1:0] CODE_LOW_CUR_WARN = 4'h9;
	localparam logic [CODE_W-1:0] CODE_HIGH_CUR_TRIP = 4'ha;
	localparam logic [CODE_W-1:0] CODE_HIGH_CUR_WARN = 4'hb;
	localparam logic [CODE_W-1:0] CODE_EARTH_TRIP = 4'hc;
	localparam logic [CODE_W-1:0] CODE_EARTH_WARN = 4'hd;
	localparam logic [CODE_W-1:0] CODE_SELFTEST = 4'he;
	localparam logic [CODE_W-1:0] CODE_ACTUATOR = 4'hf;
	// Protection trips, plus high current warning code 11, that auto acknowledge may clear
	localparam logic [NUM_CODES-1:0] PROT_MASK = 16'h1d2f;
	// Fault output config field values
	localparam logic [1:0] FOUT_OFF = 2'h0;
	localparam logic [1:0] FOUT_RELAY = 2'h1;
	localparam logic [1:0] FOUT_LAMP = 2'h2;
	localparam logic [1:0] FOUT_BOTH = 2'h3;
	typedef struct packed {
		logic [CODE_W-1:0]  code;
		logic [TIME_W-1:0]  stamp;
	} mflr_entry_t;
endpackage

// *** verilog/mflr_top.sv ***
// Motor fault latch, acknowledge, history and reporting
// Behaviour
// - A detected fault stays latched until a fault reset acknowledges it.
// - Without auto acknowledge, trips need panel, fieldbus or input acknowledge.
// - With auto acknowledge, trips clear themselves once their condition is gone.
// - History keeps the last 16 faults with seconds since power on.
// - History is volatile and empty after power up.
// - Relay and lamp outputs signal summary fault per fault output setting.
// - Red LED lights on a fault and stays until acknowledged.
// - Fieldbus fault flag is one while any fault is present.
// - Each new fault issues a diagnosis telegram when the bus supports it.
// - Thermal trip is code 0, thermal warning level is code 4.
// - Phase current below phase loss threshold is code 1.
// - One phase below imbalance threshold is code 2.
// - Locked rotor is code 3.
// - Thermistor overtemperature is code 5.
// - Code 6 sums thermistor wiring faults, code 7 sums check-back errors.
// - Low current trip is code 8, low current warning code 9.
// - High current trip is code 10, high current warning code 11.
// - Earth fault trip is code 12, earth fault warning code 13.
// - Internal self-test failure is code 14.
// - Actuator open or close time exceeded is code 15.
`timescale 1ns/10ps
module mflr_top #(
	parameter int TICKS_PER_SEC = mflr_pkg::TICKS_PER_SEC
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	input  wire logic                        thermal_trip,
	input  wire logic                        thermal_warn,
	input  wire logic                        phase_loss,
	input  wire logic                        phase_imbalance,
	input  wire logic                        locked_rotor,
	input  wire logic                        thermistor_input,
	input  wire logic [1:0]                  thermistor_wiring_fault,
	input  wire logic [2:0]                  checkback_fault,
	input  wire logic                        low_current_trip,
	input  wire logic                        low_current_warn,
	input  wire logic                        high_current_trip,
	input  wire logic                        high_current_warn,
	input  wire logic                        earth_fault_trip,
	input  wire logic                        earth_fault_warn,
	input  wire logic                        selftest_fail,
	input  wire logic                        actuator_timeout,
	input  wire logic                        auto_ack_en,
	input  wire logic [1:0]                  fault_output_cfg,
	input  wire logic                        panel_ack,
	input  wire logic                        fieldbus_ack,
	input  wire logic [2:0]                  multifunction_inputs,
	input  wire logic [2:0]                  multifunction_ack_en,
	input  wire logic                        diag_supported,
	input  wire logic                        diag_ready,
	input  wire logic [3:0]                  hist_index,
	output logic [mflr_pkg::NUM_CODES-1:0]   fault_latched,
	output logic                             fault_present,
	output logic                             fieldbus_fault_flag,
	output logic                             red_led,
	output logic                             summary_fault_relay_output,
	output logic                             summary_fault_lamp_output,
	output logic                             diag_valid,
	output logic [mflr_pkg::CODE_W-1:0]      diag_code,
	output logic [mflr_pkg::TIME_W-1:0]      diag_stamp,
	output logic [mflr_pkg::CODE_W-1:0]      hist_code,
	output logic [mflr_pkg::TIME_W-1:0]      hist_stamp,
	output logic                             hist_valid,
	output logic [4:0]                       hist_count,
	output logic [mflr_pkg::TIME_W-1:0]      seconds_since_power_on
);
	localparam int NC = mflr_pkg::NUM_CODES;
	localparam int PIN_W = 24;

	// Every register of this top module lives in this one struct; history and diagnosis keep their own
	typedef struct packed {
		logic [PIN_W-1:0]                  sync1;
		logic [PIN_W-1:0]                  sync2;
		logic [NC-1:0]                     cond;
		logic [NC-1:0]                     latched;
		logic [NC-1:0]                     pending;
		logic                              ack_prev;
		logic [31:0]                       tick;
		logic [mflr_pkg::TIME_W-1:0]       secs;
		logic                              evt_valid;
		logic [mflr_pkg::CODE_W-1:0]       evt_code;
		logic [mflr_pkg::TIME_W-1:0]       evt_stamp;
		logic                              relay;
		logic                              lamp;
		logic                              led;
	} mflr_state_t;

	mflr_state_t s_q;
	mflr_state_t s_d;
	logic [PIN_W-1:0] pins;
	logic [NC-1:0]    raw;
	logic [2:0]       mf_s;
	logic             ack_lvl;
	logic             ack_pulse;
	logic [NC-1:0]    rising;

	mflr_event_if evt_bus ();

	// Lowest code first, so simultaneous faults report in code order
	function automatic logic [mflr_pkg::CODE_W-1:0] mflr_first(input logic [NC-1:0] v);
		logic [mflr_pkg::CODE_W-1:0] r;
		r = '0;
		for (int i = NC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = mflr_pkg::CODE_W'(i);
			end
		end
		return r;
	endfunction

	assign pins = {
		multifunction_inputs,
		panel_ack,
		fieldbus_ack,
		actuator_timeout,
		selftest_fail,
		earth_fault_warn,
		earth_fault_trip,
		high_current_warn,
		high_current_trip,
		low_current_warn,
		low_current_trip,
		checkback_fault,
		thermistor_wiring_fault,
		thermistor_input,
		thermal_warn,
		locked_rotor,
		phase_imbalance,
		phase_loss,
		thermal_trip
	};

	// Map synchronised conditions onto their fault codes
	always_comb begin
		raw = '0;
		raw[mflr_pkg::CODE_THERMAL_TRIP] = s_q.sync2[0];
		raw[mflr_pkg::CODE_PHASE_LOSS] = s_q.sync2[1];
		raw[mflr_pkg::CODE_IMBALANCE] = s_q.sync2[2];
		raw[mflr_pkg::CODE_LOCKED_ROTOR] = s_q.sync2[3];
		raw[mflr_pkg::CODE_THERMAL_WARN] = s_q.sync2[4];
		raw[mflr_pkg::CODE_THERMISTOR_HOT] = s_q.sync2[5];
		raw[mflr_pkg::CODE_THERMISTOR_WIRE] = |s_q.sync2[7:6];
		raw[mflr_pkg::CODE_CHECKBACK] = |s_q.sync2[10:8];
		raw[mflr_pkg::CODE_LOW_CUR_TRIP] = s_q.sync2[11];
		raw[mflr_pkg::CODE_LOW_CUR_WARN] = s_q.sync2[12];
		raw[mflr_pkg::CODE_HIGH_CUR_TRIP] = s_q.sync2[13];
		raw[mflr_pkg::CODE_HIGH_CUR_WARN] = s_q.sync2[14];
		raw[mflr_pkg::CODE_EARTH_TRIP] = s_q.sync2[15];
		raw[mflr_pkg::CODE_EARTH_WARN] = s_q.sync2[16];
		raw[mflr_pkg::CODE_SELFTEST] = s_q.sync2[17];
		raw[mflr_pkg::CODE_ACTUATOR] = s_q.sync2[18];
	end

	assign mf_s = s_q.sync2[PIN_W-1:PIN_W-3];
	// Any acknowledge source acts on its rising edge only, so a held button clears once
	assign ack_lvl = s_q.sync2[20] | s_q.sync2[19] | (|(mf_s & multifunction_ack_en));
	assign ack_pulse = ack_lvl & ~s_q.ack_prev;
	assign rising = raw & ~s_q.cond;

	always_comb begin
		s_d = s_q;
		// Two flops per pin; only the second one feeds the fault map
		s_d.sync1 = pins;
		s_d.sync2 = s_q.sync1;
		s_d.cond = raw;
		s_d.ack_prev = ack_lvl;
		// Seconds since power on restart from zero on every reset
		if (s_q.tick == 32'(TICKS_PER_SEC - 1)) begin
			s_d.tick = '0;
			s_d.secs = s_q.secs + 32'h0000_0001;
		end else begin
			s_d.tick = s_q.tick + 32'h0000_0001;
		end
		// Manual acknowledge clears only faults whose cause is gone
		if (ack_pulse) begin
			s_d.latched = s_q.latched & raw;
		end
		// Auto acknowledge clears protection trips once their cause is gone
		if (auto_ack_en) begin
			s_d.latched = s_d.latched & ~(mflr_pkg::PROT_MASK & ~raw);
		end
		// Set wins over clear in the same cycle
		s_d.latched = s_d.latched | raw;
		// Causes that rose but are not yet logged wait here
		s_d.pending = (s_q.pending & ~(s_q.evt_valid ? (16'h0001 << s_q.evt_code) : 16'h0000)) | rising;
		s_d.evt_valid = 1'b0;
		if (s_d.pending != '0) begin
			// One history entry per cycle; a burst drains in code order
			s_d.evt_valid = !s_q.evt_valid || (s_d.pending != (16'h0001 << s_q.evt_code));
			s_d.evt_code = mflr_first(s_q.evt_valid ? (s_d.pending & ~(16'h0001 << s_q.evt_code))
				: s_d.pending);
			s_d.evt_stamp = s_q.secs;
		end
		s_d.led = |s_d.latched;
		unique case (fault_output_cfg)
			mflr_pkg::FOUT_OFF: begin
				s_d.relay = 1'b0;
				s_d.lamp = 1'b0;
			end
			mflr_pkg::FOUT_RELAY: begin
				s_d.relay = |s_d.latched;
				s_d.lamp = 1'b0;
			end
			mflr_pkg::FOUT_LAMP: begin
				s_d.relay = 1'b0;
				s_d.lamp = |s_d.latched;
			end
			mflr_pkg::FOUT_BOTH: begin
				s_d.relay = |s_d.latched;
				s_d.lamp = |s_d.latched;
			end
		endcase
	end

	// Reset empties the latches and the seconds count
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Event leaves on a register so both listeners see the same cycle
	assign evt_bus.valid = s_q.evt_valid;
	assign evt_bus.code = s_q.evt_code;
	assign evt_bus.stamp = s_q.evt_stamp;

	// History and diagnosis listen to the same one-cycle event
	mflr_history u_hist (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.evt      (evt_bus.sink),
		.rd_index (hist_index),
		.rd_code  (hist_code),
		.rd_stamp (hist_stamp),
		.rd_valid (hist_valid),
		.count    (hist_count)
	);

	mflr_diag u_diag (
		.core_clk       (core_clk),
		.reset_n        (reset_n),
		.evt            (evt_bus.sink),
		.diag_supported (diag_supported),
		.diag_ready     (diag_ready),
		.diag_valid     (diag_valid),
		.diag_code      (diag_code),
		.diag_stamp     (diag_stamp)
	);

	// The summary bit toward the bus master mirrors any latched fault
	assign fault_latched = s_q.latched;
	assign fault_present = |s_q.latched;
	assign fieldbus_fault_flag = |s_q.latched;
	assign red_led = s_q.led;
	assign summary_fault_relay_output = s_q.relay;
	assign summary_fault_lamp_output = s_q.lamp;
	assign seconds_since_power_on = s_q.secs;

	// Clear paths, watched on trip code 0; the set path on locked rotor code 3
	latch_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		$past(s_q.latched[0]) && !s_q.latched[0] |-> !$past(raw[0]) && ($past(ack_pulse) || $past(auto_ack_en)))
		else $error("latched fault cleared without acknowledge");

	latch_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		raw[mflr_pkg::CODE_LOCKED_ROTOR] |=> fault_latched[mflr_pkg::CODE_LOCKED_ROTOR])
		else $error("locked rotor not latched as code 3");

	manual_only_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!auto_ack_en && !ack_pulse && s_q.latched[0] |=> s_q.latched[0])
		else $error("trip cleared without manual acknowledge");

	auto_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		auto_ack_en && s_q.latched[0] && !raw[0] |=> !s_q.latched[0])
		else $error("auto acknowledge did not clear trip");

	led_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		raw != '0 |-> ##1 red_led ##0 fieldbus_fault_flag)
		else $error("led or fault flag missing on fault");

	flag_match_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		$past(raw) != '0 |-> fieldbus_fault_flag)
		else $error("fault flag missing after fault");

	relay_cfg_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		fault_output_cfg == mflr_pkg::FOUT_OFF |=> !summary_fault_relay_output && !summary_fault_lamp_output)
		else $error("summary output active while disabled");

	// Pin to code mapping through the two synchroniser flops; phase loss is checked from rising to the event code
	sync_path_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		thermal_trip [*3] |-> ##2 fault_latched[mflr_pkg::CODE_THERMAL_TRIP])
		else $error("thermal trip not latched as code 0");

	event_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		rising == 16'h0002 && s_q.pending == '0 && !s_q.evt_valid |=> evt_bus.valid && evt_bus.code == 4'h1)
		else $error("phase loss event not code 1");

	imbalance_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		phase_imbalance [*3] |-> ##2 fault_latched[mflr_pkg::CODE_IMBALANCE])
		else $error("imbalance not latched as code 2");

	hot_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		thermistor_input [*3] |-> ##2 fault_latched[mflr_pkg::CODE_THERMISTOR_HOT])
		else $error("thermistor overtemperature not code 5");

	wiring_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(thermistor_wiring_fault != 2'h0) [*3] |-> ##2 fault_latched[mflr_pkg::CODE_THERMISTOR_WIRE])
		else $error("thermistor wiring fault not code 6");

	checkback_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(checkback_fault != 3'h0) [*3] |-> ##2 fault_latched[mflr_pkg::CODE_CHECKBACK])
		else $error("check-back error not code 7");

	low_trip_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		low_current_trip [*3] |-> ##2 fault_latched[mflr_pkg::CODE_LOW_CUR_TRIP])
		else $error("low current trip not code 8");

	high_trip_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		high_current_trip [*3] |-> ##2 fault_latched[mflr_pkg::CODE_HIGH_CUR_TRIP])
		else $error("high current trip not code 10");

	earth_trip_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		earth_fault_trip [*3] |-> ##2 fault_latched[mflr_pkg::CODE_EARTH_TRIP])
		else $error("earth fault trip not code 12");

	selftest_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		selftest_fail [*3] |-> ##2 fault_latched[mflr_pkg::CODE_SELFTEST])
		else $error("self-test failure not code 14");

	actuator_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		actuator_timeout [*3] |-> ##2 fault_latched[mflr_pkg::CODE_ACTUATOR])
		else $error("actuator timeout not code 15");

	// Main scenarios the bench should reach
	ack_c: cover property (@(posedge core_clk) disable iff (!reset_n) ack_pulse && fault_present);
	diag_c: cover property (@(posedge core_clk) disable iff (!reset_n) diag_valid && diag_ready);
	auto_c: cover property (@(posedge core_clk) disable iff (!reset_n) auto_ack_en && $fell(fault_present));
	multi_c: cover property (@(posedge core_clk) disable iff (!reset_n) $countones(rising) > 1);
endmodule
